//--- hdl/csw_pkg.sv
// package for the clock switch, fail-safe monitor and sleep control block
// assumes one 250 MHz clock and a plain address/strobe register port
package csw_pkg;

  // ==========================================================
  // register map (word indices on the plain register port)
  localparam logic [3:0] OFS_OSC_CTRL  = 4'h0;
  localparam logic [3:0] OFS_TRIM      = 4'h1;
  localparam logic [3:0] OFS_UNLOCK    = 4'h2;
  localparam logic [3:0] OFS_PWR_CTRL  = 4'h3;
  localparam logic [3:0] OFS_OSC_STAT  = 4'h4;

  // ==========================================================
  // field positions in the oscillator control word
  localparam int POS_SWREQ   = 0;
  localparam int POS_KEEPON  = 1;
  localparam int POS_FAIL    = 3;
  localparam int POS_LOCK    = 5;
  localparam int POS_REQSEL  = 8;
  localparam int POS_ACTSEL  = 12;

  // field positions in the power control word
  localparam int POS_SLEEP_GO = 0;
  localparam int POS_WDT_EN   = 1;

  // ==========================================================
  // unlock keys, written in order to the unlock word
  localparam logic [15:0] UNLOCK_KEY_A = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY_B = 16'h00AA;

  // ==========================================================
  // reset values
  localparam logic [5:0] TRIM_RST = 6'h00;

  // ==========================================================
  // timing
  localparam int NEW_CLK_CYCLES = 10;
  localparam int OST_CYCLES     = 1024;
  localparam int PLL_LOCK_NS    = 2000;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // clock source encoding
  typedef enum logic [2:0] {
    SRC_FRC     = 3'h0,
    SRC_FRC_PLL = 3'h1,
    SRC_PRI     = 3'h2,
    SRC_PRI_PLL = 3'h3,
    SRC_SEC     = 3'h4,
    SRC_LOW_POWER_RC_OSC    = 3'h5,
    SRC_FRC_D16 = 3'h6,
    SRC_FRC_DN  = 3'h7
  } csw_src_t;

  // switch sequencer states, gray along the switch path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_START  = 3'b011,
    ST_SETTLE = 3'b010,
    ST_SWAP   = 3'b110,
    ST_SLEEP  = 3'b111
  } csw_state_t;

  // oscillator enables toward the analog side
  typedef struct packed {
    logic fast_rc_osc;
    logic pri;
    logic sec;
    logic low_power_rc_osc;
    logic pll;
  } csw_osc_en_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } csw_bus_req_t;

endpackage

//--- hdl/csw_clock_ctrl.sv
// clock source switch sequencer, fail-safe monitor fallback, trim and sleep
// assumes oscillator ready and failure indications arrive asynchronously
`timescale 1ns/1ps

module csw_clock_ctrl
  import csw_pkg::*;
#(
  parameter int OST_CYC = OST_CYCLES
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [15:0]  reg_rdata,
  // configuration straps
  input  wire logic         switch_enable_cfg,
  input  wire logic [2:0]   initial_source_cfg,
  input  wire logic [1:0]   primary_submode_cfg,
  // oscillator status, asynchronous
  input  wire logic         osc_ready_async,
  input  wire logic         pll_lock_async,
  input  wire logic         osc_fail_async,
  input  wire logic         new_clk_tick_async,
  // wake sources
  input  wire logic         wake_irq,
  input  wire logic         wdt_timeout,
  // oscillator and clock control
  output csw_osc_en_t       osc_en,
  output logic      [2:0]   sys_clk_sel,
  output logic      [1:0]   primary_submode,
  output logic      [5:0]   freq_trim_code,
  output logic              clock_fail_trap,
  output logic              wdt_clear,
  output logic              sys_clk_gate_n
);

  // ==========================================================
  // state record
  typedef struct packed {
    csw_state_t  st;
    logic [1:0]  unlock;
    logic        unlocked;
    logic [2:0]  req_sel;
    logic [2:0]  act_sel;
    logic        swreq;
    logic        keep_on;
    logic        lock_flag;
    logic        fail_flag;
    logic        wdt_en;
    logic [5:0]  trim;
    logic [15:0] cnt;
    logic        boot;
    logic        trap;
    logic        wclr;
    logic [15:0] rdata;
    logic [1:0]  rdy_s;
    logic [1:0]  lck_s;
    logic [1:0]  fail_s;
    logic [1:0]  tick_s;
    logic        tick_d;
    logic [1:0]  submode;
  } csw_state_rec_t;

  csw_state_rec_t s_reg;
  csw_state_rec_t s_next;

  // ==========================================================
  // helpers
  function automatic logic uses_pll(input logic [2:0] sel);
    return (sel == SRC_FRC_PLL) || (sel == SRC_PRI_PLL);
  endfunction

  function automatic logic uses_pri(input logic [2:0] sel);
    return (sel == SRC_PRI) || (sel == SRC_PRI_PLL);
  endfunction

  function automatic logic uses_frc(input logic [2:0] sel);
    return (sel == SRC_FRC) || (sel == SRC_FRC_PLL)
        || (sel == SRC_FRC_D16) || (sel == SRC_FRC_DN);
  endfunction

  logic sw_on;
  logic rdy;
  logic lck;
  logic fail;
  logic tick;
  logic wr_ctrl;
  logic sleeping;

  assign sw_on    = ~switch_enable_cfg;
  assign rdy      = s_reg.rdy_s[1];
  assign lck      = s_reg.lck_s[1];
  assign fail     = s_reg.fail_s[1];
  assign tick     = s_reg.tick_s[1] & ~s_reg.tick_d;
  assign sleeping = (s_reg.st == ST_SLEEP);
  assign wr_ctrl  = reg_wr && (reg_addr == OFS_OSC_CTRL) && s_reg.unlocked;

  // ==========================================================
  // next state
  always_comb begin
    s_next       = s_reg;
    s_next.trap  = 1'b0;
    s_next.wclr  = 1'b0;
    s_next.rdy_s = {s_reg.rdy_s[0], osc_ready_async};
    s_next.lck_s = {s_reg.lck_s[0], pll_lock_async};
    s_next.fail_s = {s_reg.fail_s[0], osc_fail_async};
    s_next.tick_s = {s_reg.tick_s[0], new_clk_tick_async};
    s_next.tick_d = s_reg.tick_s[1];

    // straps captured on the first clock after reset release
    if (s_reg.boot) begin
      s_next.boot    = 1'b0;
      s_next.act_sel = initial_source_cfg;
      s_next.req_sel = initial_source_cfg;
      s_next.submode = primary_submode_cfg;
    end

    // unlock sequence: key A then key B opens one control write
    if (reg_wr && (reg_addr == OFS_UNLOCK)) begin
      s_next.unlock   = (reg_wdata == UNLOCK_KEY_A) ? 2'd1 : 2'd0;
      s_next.unlocked = (s_reg.unlock == 2'd1) && (reg_wdata == UNLOCK_KEY_B);
    end else if (reg_wr || reg_rd) begin
      s_next.unlock   = 2'd0;
      s_next.unlocked = 1'b0;
    end

    if (reg_wr && (reg_addr == OFS_TRIM))
      s_next.trim = reg_wdata[5:0];
    if (reg_wr && (reg_addr == OFS_PWR_CTRL))
      s_next.wdt_en = reg_wdata[POS_WDT_EN];

    // control word write; source select and switch request only while switching is allowed
    if (wr_ctrl) begin
      s_next.keep_on = reg_wdata[POS_KEEPON];
      if (sw_on) begin
        s_next.req_sel = reg_wdata[POS_REQSEL +: 3];
        if (reg_wdata[POS_SWREQ] && s_reg.st == ST_IDLE)
          s_next.swreq = 1'b1;
      end
      // fail flag clears by writing zero; a failure still present sets it again one cycle later below
      if (!reg_wdata[POS_FAIL])
        s_next.fail_flag = 1'b0;
    end

    if (!sw_on) begin
      s_next.swreq   = 1'b0;
      s_next.act_sel = s_reg.boot ? initial_source_cfg : s_reg.act_sel;
    end

    unique case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.swreq && sw_on)
          s_next.st = ST_CHECK;
      end
      ST_CHECK: begin
        if (s_reg.act_sel == s_reg.req_sel) begin
          s_next.swreq = 1'b0;
          s_next.st    = ST_IDLE;
        end else begin
          s_next.lock_flag = 1'b0;
          s_next.fail_flag = 1'b0;
          s_next.cnt       = 16'h0000;
          s_next.st        = ST_START;
        end
      end
      ST_START: begin
        // crystal start-up then PLL lock, when the new source needs them
        if (uses_pri(s_reg.req_sel) && s_reg.cnt < 16'(OST_CYC)) begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end else if (uses_pri(s_reg.req_sel) && !rdy) begin
          s_next.cnt = s_reg.cnt;
        end else if (uses_pll(s_reg.req_sel) && !lck) begin
          s_next.cnt = s_reg.cnt;
        end else begin
          s_next.lock_flag = uses_pll(s_reg.req_sel);
          s_next.cnt       = 16'h0000;
          s_next.st        = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tick)
          s_next.cnt = s_reg.cnt + 16'h0001;
        if (s_reg.cnt == 16'(NEW_CLK_CYCLES))
          s_next.st = ST_SWAP;
      end
      ST_SWAP: begin
        s_next.act_sel = s_reg.req_sel;
        s_next.swreq   = 1'b0;
        s_next.st      = ST_IDLE;
      end
      ST_SLEEP: begin
        if (wake_irq || wdt_timeout)
          s_next.st = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase

    // sleep entry from the power control word
    if (reg_wr && (reg_addr == OFS_PWR_CTRL) && reg_wdata[POS_SLEEP_GO]
        && s_reg.st == ST_IDLE) begin
      s_next.st   = ST_SLEEP;
      s_next.wclr = reg_wdata[POS_WDT_EN];
    end

    // fail-safe monitor, active only with switching and outside sleep
    if (sw_on && fail && !sleeping && !s_reg.fail_flag) begin
      s_next.fail_flag = 1'b1;
      s_next.trap      = 1'b1;
      s_next.act_sel   = uses_pll(s_reg.act_sel) ? SRC_FRC_PLL : SRC_FRC;
      s_next.req_sel   = s_next.act_sel;
      s_next.swreq     = 1'b0;
      s_next.st        = ST_IDLE;
    end

    // register read, data stand one cycle later
    s_next.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_OSC_CTRL: begin
          s_next.rdata[POS_ACTSEL +: 3] = s_reg.act_sel;
          s_next.rdata[POS_REQSEL +: 3] = s_reg.req_sel;
          s_next.rdata[POS_LOCK]        = s_reg.lock_flag;
          s_next.rdata[POS_FAIL]        = s_reg.fail_flag;
          s_next.rdata[POS_KEEPON]      = s_reg.keep_on;
          s_next.rdata[POS_SWREQ]       = s_reg.swreq;
        end
        OFS_TRIM:     s_next.rdata[5:0] = s_reg.trim;
        OFS_PWR_CTRL: s_next.rdata[POS_WDT_EN] = s_reg.wdt_en;
        OFS_OSC_STAT: s_next.rdata[2:0] = s_reg.st;
        default:      s_next.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg      <= '0;
      s_reg.st   <= ST_IDLE;
      s_reg.trim <= TRIM_RST;
      s_reg.boot <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  logic mon_on;
  logic switching;
  assign mon_on    = sw_on & ~sleeping;
  assign switching = (s_reg.st == ST_START) || (s_reg.st == ST_SETTLE)
                  || (s_reg.st == ST_SWAP);

  always_comb begin
    osc_en      = '0;
    if (!sleeping) begin
      osc_en.fast_rc_osc = uses_frc(s_reg.act_sel) || (switching && uses_frc(s_reg.req_sel));
      osc_en.pri = uses_pri(s_reg.act_sel) || (switching && uses_pri(s_reg.req_sel));
      osc_en.pll = uses_pll(s_reg.act_sel) || (switching && uses_pll(s_reg.req_sel));
    end
    osc_en.sec  = s_reg.keep_on || (!sleeping && (s_reg.act_sel == SRC_SEC
                || (switching && s_reg.req_sel == SRC_SEC)));
    osc_en.low_power_rc_osc = mon_on || s_reg.wdt_en
                || (!sleeping && s_reg.act_sel == SRC_LOW_POWER_RC_OSC);
  end

  assign sys_clk_sel     = s_reg.act_sel;
  assign primary_submode = s_reg.submode;
  assign freq_trim_code  = s_reg.trim;
  assign clock_fail_trap = s_reg.trap;
  assign wdt_clear       = s_reg.wclr;
  assign sys_clk_gate_n  = ~sleeping;
  assign reg_rdata       = s_reg.rdata;

endmodule // csw_clock_ctrl

//--- tb/csw_clock_ctrl_sva.sv
// assertions for the clock switch, fail monitor and sleep block
// assumes straps change only while nrst is low
`timescale 1ns/1ps
module csw_clock_ctrl_sva
  import csw_pkg::*;
#(
  parameter int OST_CYC = OST_CYCLES
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // straps and events
  input wire logic        switch_enable_cfg,
  input wire logic [2:0]  initial_source_cfg,
  input wire logic        osc_fail_async,
  input wire logic        wake_irq,
  input wire logic        wdt_timeout,
  // clock control
  input wire csw_osc_en_t osc_en,
  input wire logic [2:0]  sys_clk_sel,
  input wire logic [1:0]  primary_submode,
  input wire logic [5:0]  freq_trim_code,
  input wire logic        clock_fail_trap,
  input wire logic        wdt_clear,
  input wire logic        sys_clk_gate_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // registers
  property trim_p;
    logic [5:0] t;
    (reg_wr && reg_addr == OFS_TRIM, t = reg_wdata[5:0]) |=> freq_trim_code == t;
  endproperty
  trim_load_a: assert property (trim_p)
    else $error("trim code not loaded");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  // ==========================================================
  // switching disabled, and primary submode fixed after boot
  fixed_source_a: assert property (switch_enable_cfg && $past(nrst, 2) |->
    sys_clk_sel == initial_source_cfg) else $error("source moved while locked");
  no_trap_off_a: assert property (clock_fail_trap |-> !switch_enable_cfg)
    else $error("trap with monitor disabled");
  submode_fixed_a: assert property ($past(nrst, 2) |-> $stable(primary_submode))
    else $error("primary submode changed");
  // ==========================================================
  // fail monitor
  fail_trap_a: assert property ($rose(osc_fail_async) && !switch_enable_cfg
    && sys_clk_gate_n |-> ##[1:6] clock_fail_trap) else $error("no trap on failure");
  trap_fallback_a: assert property (clock_fail_trap |-> ##[0:1]
    sys_clk_sel inside {SRC_FRC, SRC_FRC_PLL}) else $error("no fallback to fast rc");
  low_power_rc_osc_kept_a: assert property (!switch_enable_cfg && sys_clk_gate_n
    && $past(sys_clk_gate_n) && $past(nrst) |-> osc_en.low_power_rc_osc) else $error("low_power_rc_osc off");
  // ==========================================================
  // sleep
  sleep_osc_off_a: assert property (!sys_clk_gate_n |->
    !(osc_en.fast_rc_osc || osc_en.pri || osc_en.pll)) else $error("oscillator on in sleep");
  sleep_no_trap_a: assert property (!sys_clk_gate_n |-> !clock_fail_trap)
    else $error("trap during sleep");
  sleep_hold_sel_a: assert property (!sys_clk_gate_n |-> $stable(sys_clk_sel))
    else $error("source changed in sleep");
  wdt_sleep_a: assert property (wdt_clear |-> ##[0:2] !sys_clk_gate_n)
    else $error("watchdog clear without sleep");
  wake_exit_a: assert property (!sys_clk_gate_n && (wake_irq || wdt_timeout)
    |-> ##[1:4] sys_clk_gate_n) else $error("no wake");
  cover property (clock_fail_trap);
  cover property ($fell(sys_clk_gate_n));
  cover property ($changed(sys_clk_sel) && !clock_fail_trap);
endmodule // csw_clock_ctrl_sva

bind csw_clock_ctrl csw_clock_ctrl_sva #(.OST_CYC(OST_CYC)) chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .switch_enable_cfg(switch_enable_cfg), .initial_source_cfg(initial_source_cfg),
  .osc_fail_async(osc_fail_async), .wake_irq(wake_irq), .wdt_timeout(wdt_timeout),
  .osc_en(osc_en), .sys_clk_sel(sys_clk_sel), .primary_submode(primary_submode),
  .freq_trim_code(freq_trim_code), .clock_fail_trap(clock_fail_trap),
  .wdt_clear(wdt_clear), .sys_clk_gate_n(sys_clk_gate_n));

//--- tb/csw_clock_ctrl_tb.sv
// self-checking bench for the clock switch, fail monitor and sleep block
// assumes the package and design of hdl/ are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module csw_clock_ctrl_tb;
  import csw_pkg::*;
  logic        ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic        switch_enable_cfg = 0, osc_ready_async = 0, pll_lock_async = 0;
  logic [2:0]  initial_source_cfg = 0, sys_clk_sel;
  logic [1:0]  primary_submode_cfg = 2'h1, primary_submode;
  logic        osc_fail_async = 0, new_clk_tick_async = 0, wake_irq = 0, wdt_timeout = 0;
  csw_osc_en_t osc_en;
  logic [5:0]  freq_trim_code;
  logic        clock_fail_trap, wdt_clear, sys_clk_gate_n, got;
  int          n_errors = 0, check_count = 0, n;

  csw_clock_ctrl #(.OST_CYC(8)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .switch_enable_cfg(switch_enable_cfg), .initial_source_cfg(initial_source_cfg),
    .primary_submode_cfg(primary_submode_cfg), .osc_ready_async(osc_ready_async),
    .pll_lock_async(pll_lock_async), .osc_fail_async(osc_fail_async),
    .new_clk_tick_async(new_clk_tick_async), .wake_irq(wake_irq),
    .wdt_timeout(wdt_timeout), .osc_en(osc_en), .sys_clk_sel(sys_clk_sel),
    .primary_submode(primary_submode), .freq_trim_code(freq_trim_code),
    .clock_fail_trap(clock_fail_trap), .wdt_clear(wdt_clear),
    .sys_clk_gate_n(sys_clk_gate_n));

  always #2 ref_clk = ~ref_clk;
  // new source clock, five system cycles a period
  always #10 new_clk_tick_async <= ~new_clk_tick_async;

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask
  task automatic ctrl(input logic [15:0] d);
    wr(OFS_UNLOCK, UNLOCK_KEY_A);
    wr(OFS_UNLOCK, UNLOCK_KEY_B);
    wr(OFS_OSC_CTRL, d);
  endtask
  task automatic wait_sel(input logic [2:0] s);
    n = 0;
    while (sys_clk_sel !== s && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(sys_clk_sel, s)
  endtask
  task automatic do_reset(input logic en, input logic [2:0] init);
    nrst <= 1'b0;
    switch_enable_cfg <= en;
    initial_source_cfg <= init;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic conclude();
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_trim();
    logic [15:0] v [4] = '{16'h001F, 16'h0020, 16'h003F, 16'hFFE0};
    rd(OFS_TRIM, 16'h0000);
    rd(OFS_OSC_STAT, 16'h0000);
    rd(4'hF, 16'h0000);
    `CHK(primary_submode, 2'h1)
    foreach (v[i]) begin
      wr(OFS_TRIM, v[i]);
      rd(OFS_TRIM, v[i] & 16'h003F);
      `CHK(freq_trim_code, v[i][5:0])
    end
    wr(OFS_UNLOCK, UNLOCK_KEY_A);
    wr(OFS_UNLOCK, UNLOCK_KEY_B);
    rd(OFS_OSC_CTRL, 16'h0000);
    wr(OFS_OSC_CTRL, 16'h0400);
    rd(OFS_OSC_CTRL, 16'h0000);
    ctrl(16'h0000);
    ctrl(16'h0001);
    repeat (8) @(posedge ref_clk);
    rd(OFS_OSC_CTRL, 16'h0000);
  endtask
  task automatic t_switch();
    ctrl(16'h0400);
    ctrl(16'h0401);
    wait_sel(SRC_SEC);
    `CHK(n >= 40, 1'b1)
    rd(OFS_OSC_CTRL, 16'h4400, 16'h7709);
    `CHK({osc_en.fast_rc_osc, osc_en.sec, osc_en.low_power_rc_osc}, 3'b011)
    ctrl(16'h0300);
    ctrl(16'h0301);
    repeat (100) @(posedge ref_clk);
    `CHK(sys_clk_sel, SRC_SEC)
    osc_ready_async <= 1'b1;
    pll_lock_async <= 1'b1;
    wait_sel(SRC_PRI_PLL);
    rd(OFS_OSC_CTRL, 16'h3320, 16'h7729);
    `CHK({osc_en.sec, osc_en.pri, osc_en.pll}, 3'b011)
  endtask
  task automatic t_fail();
    got = 0;
    osc_fail_async <= 1'b1;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      if (clock_fail_trap === 1'b1) got = 1;
    end
    `CHK(got, 1'b1)
    `CHK(sys_clk_sel, SRC_FRC_PLL)
    rd(OFS_OSC_CTRL, 16'h1008, 16'h7008);
    osc_fail_async <= 1'b0;
    ctrl(16'h0100);
    rd(OFS_OSC_CTRL, 16'h0000, 16'h0008);
    ctrl(16'h0600);
    ctrl(16'h0601);
    wait_sel(SRC_FRC_D16);
    `CHK({osc_en.fast_rc_osc, osc_en.pll, osc_en.pri}, 3'b100)
  endtask
  task automatic t_sleep(input int src);
    got = 0;
    wr(OFS_PWR_CTRL, 16'h0003);
    repeat (4) begin
      #1;
      if (wdt_clear === 1'b1) got = 1;
      @(posedge ref_clk);
    end
    `CHK(got, 1'b1)
    `CHK({sys_clk_gate_n, osc_en.fast_rc_osc, osc_en.pll, osc_en.low_power_rc_osc}, 4'b0001)
    if (src == 0) wake_irq <= 1'b1;
    else wdt_timeout <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    wdt_timeout <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK(sys_clk_gate_n, 1'b1)
    `CHK(sys_clk_sel, SRC_FRC_D16)
  endtask
  task automatic t_locked();
    do_reset(1'b1, SRC_LOW_POWER_RC_OSC);
    `CHK(sys_clk_sel, SRC_LOW_POWER_RC_OSC)
    ctrl(16'h0201);
    rd(OFS_OSC_CTRL, 16'h5000, 16'h7001);
    osc_fail_async <= 1'b1;
    repeat (60) @(posedge ref_clk);
    `CHK(sys_clk_sel, SRC_LOW_POWER_RC_OSC)
  endtask

  initial begin
    do_reset(1'b0, SRC_FRC);
    t_reset_trim();
    t_switch();
    t_fail();
    t_sleep(0);
    t_sleep(1);
    t_locked();
    conclude();
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule // csw_clock_ctrl_tb
